// ### hw/sadc_ctrl.sv
// successive approximation converter control with register port
//
// Behaviour
// - clock field: 00 Fosc/2, 01 Fosc/8, 10 Fosc/32, 11 internal rc
// - channel codes 000 to 100 route inputs 0 to 4
// - writing go with power on starts; go reads one while converting
// - at end: load result pair, clear go, set interrupt flag
// - power bit one runs converter; zero shuts it off
// - unimplemented control bits read zero
// - format one: right justified, top six high bits zero
// - format zero: left justified, low six low bits zero
// - config code picks positive and negative reference sources
// - config code marks each input pin analog or digital
// - two bit periods with hold capacitor disconnected after conversion
// - sleep conversion only with the rc clock
// - one result bit decided per bit period
// - clearing go aborts; result pair keeps old value
// - rc clock: wait one instruction cycle before converting
// - sleep with non-rc clock aborts and powers off; power bit stays
// - reset: converter off, pins analog, result pair untouched
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module sadc_ctrl
   import sadc_pkg::*;
(
   // clock and reset
   input  wire logic                clock_i,
   input  wire logic                resetn_i,
   // register port
   input  wire logic [7:0]          addr_i,
   input  wire logic [7:0]          wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [7:0]          rdata_o,
   // system
   input  wire logic                sleep_i,
   input  wire logic                rc_osc_i,
   output logic                     conv_interrupt_flag_o,
   // analog front end
   input  wire logic                comp_i,
   output logic                     conv_power_o,
   output logic                     sample_o,
   output logic      [N_CH-1:0]     chan_sel_o,
   output logic      [RES_BITS-1:0] dac_code_o,
   output logic      [N_CH-1:0]     analog_pin_o,
   output logic                     vref_pos_pin_o,
   output logic                     vref_neg_pin_o
);

   sadc_state_t         state_r;
   sadc_state_t         state_nxt;
   logic [1:0]          clk_r;
   logic [2:0]          ch_r;
   logic                go_r;
   logic                go_nxt;
   logic                pwr_r;
   logic                fmt_r;
   logic [3:0]          cfg_r;
   logic                flag_r;
   logic                flag_nxt;
   logic [7:0]          res_h_r;
   logic [7:0]          res_l_r;
   logic [3:0]          idx_r;
   logic [3:0]          idx_nxt;
   logic [RES_BITS-1:0] sar_r;
   logic [RES_BITS-1:0] sar_nxt;
   logic [2:0]          cnt_r;
   logic [2:0]          cnt_nxt;
   logic                comp1_r;
   logic                comp2_r;
   logic                comp3_r;
   logic                comp_lvl_r;
   logic [7:0]          rdata_nxt;

   // address decode and events
   logic                wr_ca;
   logic                wr_pc;
   logic                wr_rh;
   logic                wr_rl;
   logic                wr_st;
   logic                busy;
   logic                rc_sel;
   logic                sleep_kill;
   logic                tick;
   logic                start;
   logic                abort;
   logic                last_bit;
   logic                done;
   logic                hold_end;
   logic [RES_BITS-1:0] trial;
   logic [RES_BITS-1:0] final_res;
   logic [7:0]          load_h;
   logic [7:0]          load_l;
   logic                sample_nxt;

   assign wr_ca      = wr_i && (addr_i == OFS_CTRL_A);
   assign wr_pc      = wr_i && (addr_i == OFS_PORT_CONFIG_FIELD);
   assign wr_rh      = wr_i && (addr_i == OFS_RES_H);
   assign wr_rl      = wr_i && (addr_i == OFS_RES_L);
   assign wr_st      = wr_i && (addr_i == OFS_STAT);
   assign busy       = (state_r == ST_RCWAIT) || (state_r == ST_FIRST) ||
                       (state_r == ST_BITS);
   assign rc_sel     = (clk_r == CLK_RC);
   assign sleep_kill = sleep_i && !rc_sel;
   // a start needs power already on, not set in the same write
   assign start      = wr_ca && wdata_i[CA_GO] && pwr_r && !sleep_kill &&
                       (state_r == ST_IDLE);
   // abort by go clear, power off or sleep on a system clock
   assign abort      = busy && ((wr_ca && !wdata_i[CA_GO]) || !pwr_r ||
                       (wr_ca && !wdata_i[CA_PWR]) ||
                       sleep_kill);
   assign last_bit   = (state_r == ST_BITS) && tick && (idx_r == 4'h0);
   assign done       = last_bit && !abort;
   assign hold_end   = (state_r == ST_HOLD) && tick && (cnt_r == HOLD_LAST);

   // trial code for the bit under test and the finished result
   assign trial      = sar_r | (10'h001 << idx_r);
   assign final_res  = comp_lvl_r ? trial : sar_r;
   assign load_h     = fmt_r ? {6'h00, final_res[9:8]}
                             : final_res[9:2];
   assign load_l     = fmt_r ? final_res[7:0]
                             : {final_res[1:0], 6'h00};

   // bit period ticks from the selected clock source
   sadc_tad_gen u_tad (
      .clock_i   (clock_i),
      .resetn_i  (resetn_i),
      .run_i     (state_r != ST_IDLE),
      .clk_sel_i (clk_r),
      .rc_osc_i  (rc_osc_i),
      .tick_o    (tick)
   );

   // sequencer: rc wait, first segment, ten bit periods, hold-off
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = 3'h0;
      idx_nxt   = idx_r;
      sar_nxt   = sar_r;
      unique case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = rc_sel ? ST_RCWAIT : ST_FIRST;
            end
         end
         ST_RCWAIT: begin
            cnt_nxt = cnt_r + 3'h1;
            if (abort) begin
               state_nxt = ST_HOLD;
               cnt_nxt   = 3'h0;
            end else if (cnt_r == RCW_LAST) begin
               state_nxt = ST_FIRST;
               cnt_nxt   = 3'h0;
            end
         end
         ST_FIRST: begin
            if (abort) begin
               state_nxt = ST_HOLD;
            end else if (tick) begin
               state_nxt = ST_BITS;
               idx_nxt   = IDX_MSB;
               sar_nxt   = '0;
            end
         end
         ST_BITS: begin
            if (abort) begin
               state_nxt = ST_HOLD;
            end else if (tick) begin
               sar_nxt = final_res;
               if (idx_r == 4'h0) begin
                  state_nxt = ST_HOLD;
               end else begin
                  idx_nxt = idx_r - 4'h1;
               end
            end
         end
         ST_HOLD: begin
            cnt_nxt = tick ? cnt_r + 3'h1 : cnt_r;
            if (hold_end) begin
               state_nxt = ST_IDLE;
               cnt_nxt   = 3'h0;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 3'h0;
         idx_r   <= 4'h0;
         sar_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         idx_r   <= idx_nxt;
         sar_r   <= sar_nxt;
      end
   end

   // comparator synchroniser; a change counts when stages two and three agree
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         comp1_r    <= 1'b0;
         comp2_r    <= 1'b0;
         comp3_r    <= 1'b0;
         comp_lvl_r <= 1'b0;
      end else begin
         comp1_r    <= comp_i;
         comp2_r    <= comp1_r;
         comp3_r    <= comp2_r;
         comp_lvl_r <= (comp2_r == comp3_r) ? comp3_r : comp_lvl_r;
      end
   end

   // go bit and interrupt flag; the hardware set beats a software clear
   assign go_nxt   = start ? 1'b1 : (done || abort) ? 1'b0 : go_r;
   assign flag_nxt = done ? 1'b1 :
                     wr_st ? wdata_i[ST_FLAG] : flag_r;

   // control registers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clk_r  <= 2'h0;
         ch_r   <= 3'h0;
         pwr_r  <= 1'b0;
         go_r   <= 1'b0;
         fmt_r  <= 1'b0;
         cfg_r  <= 4'h0;
         flag_r <= 1'b0;
      end else begin
         if (wr_ca) begin
            clk_r <= wdata_i[CA_CLK_LSB +: 2];
            ch_r  <= wdata_i[CA_CH_LSB +: 3];
            pwr_r <= wdata_i[CA_PWR];
         end
         if (wr_pc) begin
            fmt_r <= wdata_i[PC_FMT];
            cfg_r <= wdata_i[3:0];
         end
         go_r   <= go_nxt;
         flag_r <= flag_nxt;
      end
   end

   // result pair has no reset so a reset leaves it untouched
   always_ff @(posedge clock_i) begin
      if (done) begin
         res_h_r <= load_h;
         res_l_r <= load_l;
      end else begin
         if (wr_rh) begin
            res_h_r <= wdata_i;
         end
         if (wr_rl) begin
            res_l_r <= wdata_i;
         end
      end
   end

   // read mux; unimplemented bits and unmapped addresses read zero
   assign rdata_nxt =
      (addr_i == OFS_CTRL_A) ? {clk_r, ch_r, go_r, 1'b0, pwr_r} :
      (addr_i == OFS_PORT_CONFIG_FIELD)   ? {fmt_r, 3'h0, cfg_r} :
      (addr_i == OFS_RES_H)  ? res_h_r :
      (addr_i == OFS_RES_L)  ? res_l_r :
      (addr_i == OFS_STAT)   ? {7'h00, flag_r} : 8'h00;

   // sample switch closed only while idle or waiting for the rc clock
   assign sample_nxt = pwr_r && !sleep_kill &&
      ((state_nxt == ST_IDLE) || (state_nxt == ST_RCWAIT));

   // registered outputs to the analog side and the bus
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o        <= 8'h00;
         conv_power_o   <= 1'b0;
         sample_o       <= 1'b0;
         chan_sel_o     <= '0;
         dac_code_o     <= '0;
         analog_pin_o   <= PIN_ALL;
         vref_pos_pin_o <= 1'b0;
         vref_neg_pin_o <= 1'b0;
      end else begin
         rdata_o        <= rd_i ? rdata_nxt : 8'h00;
         conv_power_o   <= pwr_r && !sleep_kill;
         sample_o       <= sample_nxt;
         chan_sel_o     <= (pwr_r && ch_r <= CH_LAST) ?
                           5'(5'h01 << ch_r) : 5'h00;
         dac_code_o     <= (state_r == ST_BITS) ? trial : '0;
         analog_pin_o   <= pin_mask(cfg_r);
         vref_pos_pin_o <= vref_pos(cfg_r);
         vref_neg_pin_o <= vref_neg(cfg_r);
      end
   end

   assign conv_interrupt_flag_o = flag_r;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   AST_GO_START: assert property (start |=> go_r && rdata_o == 8'h00)
      else $error("go not set after start");
   AST_DONE_LOAD: assert property (done |=> !go_r && flag_r &&
      state_r == ST_HOLD)
      else $error("completion did not clear go and set flag");
   AST_RIGHT: assert property (done && fmt_r |=> res_h_r[7:2] == 6'h00)
      else $error("right justified high bits not zero");
   AST_LEFT: assert property (done && !fmt_r |=> res_l_r[5:0] == 6'h00)
      else $error("left justified low bits not zero");
   AST_ABORT_KEEP: assert property (abort |=> !go_r &&
      res_h_r == $past(res_h_r) && res_l_r == $past(res_l_r))
      else $error("abort changed result pair");
   AST_HOLD: assert property (done |=> !sample_o [*3])
      else $error("sample switch closed during hold-off");
   AST_RC_WAIT: assert property (state_r == ST_FIRST &&
      $past(state_r) == ST_RCWAIT |-> $past(state_r, 4) == ST_RCWAIT)
      else $error("rc wait shorter than an instruction cycle");
   AST_CHAN: assert property (ch_r > CH_LAST |=> chan_sel_o == 5'h00)
      else $error("reserved channel selected an input");
   AST_POWER: assert property (!pwr_r |=> !conv_power_o)
      else $error("converter powered while off");
   AST_SLEEP: assert property (sleep_kill && busy |=> !go_r &&
      !conv_power_o && pwr_r == $past(pwr_r))
      else $error("sleep did not abort conversion");
   AST_RESV: assert property (rd_i && addr_i == OFS_PORT_CONFIG_FIELD |=>
      rdata_o[6:4] == 3'h0)
      else $error("unimplemented bits read nonzero");

   COV_DONE_RIGHT: cover property (done && fmt_r);
   COV_DONE_LEFT: cover property (done && !fmt_r && rc_sel);
   COV_ABORT: cover property (abort && state_r == ST_BITS);
   COV_SLEEP: cover property (sleep_kill && busy);

endmodule

// ### hw/sadc_pkg.sv
// package: register map, field layout, codes and decoders of the converter
package sadc_pkg;

   // register offsets
   localparam logic [7:0] OFS_CTRL_A = 8'h1F;
   localparam logic [7:0] OFS_PORT_CONFIG_FIELD   = 8'h9F;
   localparam logic [7:0] OFS_RES_H  = 8'h1E;
   localparam logic [7:0] OFS_RES_L  = 8'h9E;
   localparam logic [7:0] OFS_STAT   = 8'h20;

   // field positions
   localparam int CA_CLK_LSB = 6;
   localparam int CA_CH_LSB  = 3;
   localparam int CA_GO      = 2;
   localparam int CA_PWR     = 0;
   localparam int PC_FMT     = 7;
   localparam int ST_FLAG    = 0;

   // conversion clock codes and divide ratios
   localparam logic [1:0] CLK_DIV2  = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_RC    = 2'h3;
   localparam logic [5:0] DIV2      = 6'h02;
   localparam logic [5:0] DIV8      = 6'h08;
   localparam logic [5:0] DIV32     = 6'h20;

   // converter geometry and timing
   localparam int         RES_BITS  = 10;
   localparam int         N_CH      = 5;
   localparam logic [2:0] CH_LAST   = 3'h4;
   localparam logic [2:0] RCW_LAST  = 3'h3; // one instruction cycle, 4 clocks
   localparam logic [2:0] HOLD_LAST = 3'h1; // two bit periods
   localparam logic [3:0] IDX_MSB   = 4'h9;

   // pin masks, bit n is input n
   localparam logic [4:0] PIN_ALL    = 5'h1F;
   localparam logic [4:0] PIN_NO_42  = 5'h0B;
   localparam logic [4:0] PIN_NONE   = 5'h00;
   localparam logic [4:0] PIN_NO_4   = 5'h0F;
   localparam logic [4:0] PIN_ONLY_0 = 5'h01;
   localparam logic [4:0] PIN_NO_41  = 5'h0D;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_RCWAIT = 5'h02,
      ST_FIRST  = 5'h04,
      ST_BITS   = 5'h08,
      ST_HOLD   = 5'h10
   } sadc_state_t;

   // analog (non-digital) pins per port configuration code
   function automatic logic [4:0] pin_mask(input logic [3:0] cfg);
      logic [4:0] m;
      m = PIN_ALL;
      case (cfg)
         4'h4, 4'h5: m = PIN_NO_42;
         4'h6, 4'h7: m = PIN_NONE;
         4'hD:       m = PIN_NO_4;
         4'hE:       m = PIN_ONLY_0;
         4'hF:       m = PIN_NO_41;
         default:    m = PIN_ALL;
      endcase
      return m;
   endfunction

   // positive reference taken from the pin
   function automatic logic vref_pos(input logic [3:0] cfg);
      return cfg inside {4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD,
                         4'hF};
   endfunction

   // negative reference taken from the pin
   function automatic logic vref_neg(input logic [3:0] cfg);
      return cfg inside {4'h8, 4'hB, 4'hC, 4'hD, 4'hF};
   endfunction

endpackage

// ### hw/sadc_tad_gen.sv
// bit period tick generator: system clock divider or synchronised rc clock
`timescale 1ns/100ps
module sadc_tad_gen
   import sadc_pkg::*;
(
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       resetn_i,
   // control
   input  wire logic       run_i,
   input  wire logic [1:0] clk_sel_i,
   input  wire logic       rc_osc_i,
   // tick
   output logic            tick_o
);

   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic [5:0] div;
   logic       div_hit;
   logic       rc1_r;
   logic       rc2_r;
   logic       rc3_r;
   logic       rc_lvl_r;
   logic       rc_rise;
   logic       tick_nxt;

   // divider selection and rc edge detection on the settled level
   assign div      = (clk_sel_i == CLK_DIV2) ? DIV2 :
                     (clk_sel_i == CLK_DIV8) ? DIV8 : DIV32;
   assign div_hit  = (cnt_r == div - 6'h01);
   assign cnt_nxt  = (!run_i || div_hit) ? 6'h00 : cnt_r + 6'h01;
   assign rc_rise  = (rc2_r == rc3_r) && rc3_r && !rc_lvl_r;
   assign tick_nxt = run_i && ((clk_sel_i == CLK_RC) ? rc_rise : div_hit);

   // divider counter and tick register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r  <= 6'h00;
         tick_o <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_o <= tick_nxt;
      end
   end

   // three stage synchroniser for the rc oscillator
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rc1_r    <= 1'b0;
         rc2_r    <= 1'b0;
         rc3_r    <= 1'b0;
         rc_lvl_r <= 1'b0;
      end else begin
         rc1_r    <= rc_osc_i;
         rc2_r    <= rc1_r;
         rc3_r    <= rc2_r;
         rc_lvl_r <= (rc2_r == rc3_r) ? rc3_r : rc_lvl_r;
      end
   end

endmodule

// ### testbench/sadc_afe_model.sv
// analog side model: hold capacitor, comparator and internal rc oscillator
`timescale 1ns/100ps
module sadc_afe_model
   import sadc_pkg::*;
(
   // clock
   input  wire logic                         clock_i,
   // converter side
   input  wire logic                         conv_power_i,
   input  wire logic                         sample_i,
   input  wire logic [N_CH-1:0]              chan_sel_i,
   input  wire logic [RES_BITS-1:0]          dac_code_i,
   input  wire logic [N_CH-1:0][RES_BITS-1:0] level_i,
   // answers
   output logic                              comp_o,
   output logic                              rc_osc_o
);
   logic [RES_BITS-1:0] held_r = '0;
   logic                junk_r = 1'b0;

   // capacitor follows the routed input only while connected
   always_ff @(posedge clock_i) begin
      junk_r <= ~junk_r;
      for (int i = 0; i < N_CH; i++)
         if (sample_i && conv_power_i && chan_sel_i[i])
            held_r <= level_i[i];
   end

   // trial code against held level; toggles when unpowered
   assign comp_o = conv_power_i ? (held_r >= dac_code_i) : junk_r;

   // free running rc oscillator, unrelated to the system clock
   initial begin
      rc_osc_o = 1'b0;
      forever #48.5 rc_osc_o = ~rc_osc_o;
   end
endmodule

// ### testbench/sar_adc_control_bench.sv
// self-checking bench of the converter control block
`timescale 1ns/100ps
module sar_adc_control_bench
   import sadc_pkg::*;
;
   logic                         clock_i, resetn_i, wr_i, rd_i, sleep_i;
   logic [7:0]                   addr_i, wdata_i, rdata_o, d;
   logic                         rc_osc_i, comp_i, irq_flag, conv_power_o;
   logic                         sample_o, vref_pos_pin_o, vref_neg_pin_o;
   logic [N_CH-1:0]              chan_sel_o, analog_pin_o;
   logic [RES_BITS-1:0]          dac_code_o;
   logic [N_CH-1:0][RES_BITS-1:0] lvl;
   logic [15:0]                  last_res;
   logic [31:0]                  rnd;
   logic [2:0]                   ch;
   logic [1:0]                   ck;
   int                           failures = 0;
   int                           cmp_count = 0;
   int                           cyc = 0;

   sadc_ctrl i_dut (
      .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sleep_i(sleep_i), .rc_osc_i(rc_osc_i),
      .conv_interrupt_flag_o(irq_flag), .comp_i(comp_i),
      .conv_power_o(conv_power_o), .sample_o(sample_o),
      .chan_sel_o(chan_sel_o), .dac_code_o(dac_code_o),
      .analog_pin_o(analog_pin_o), .vref_pos_pin_o(vref_pos_pin_o),
      .vref_neg_pin_o(vref_neg_pin_o));

   sadc_afe_model i_afe (
      .clock_i(clock_i), .conv_power_i(conv_power_o), .sample_i(sample_o),
      .chan_sel_i(chan_sel_o), .dac_code_i(dac_code_o), .level_i(lvl),
      .comp_o(comp_i), .rc_osc_o(rc_osc_i));

   // system clock and cycle count
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i) cyc <= cyc + 1;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // {pos ref pin, neg ref pin, analog pins} per port config code
   function automatic logic [6:0] exp_cfg(input logic [3:0] c);
      case (c)
         4'h0, 4'h2, 4'h9: return 7'h1F;
         4'h1, 4'h3, 4'hA: return {2'h2, 5'h1F};
         4'h4: return 7'h0B;
         4'h5: return {2'h2, 5'h0B};
         4'h6, 4'h7: return 7'h00;
         4'h8, 4'hB, 4'hC: return {2'h3, 5'h1F};
         4'hD: return {2'h3, 5'h0F};
         4'hE: return 7'h01;
         default: return {2'h3, 5'h0D};
      endcase
   endfunction

   function automatic logic [15:0] exp_res(input logic [9:0] v, input logic f);
      return f ? {6'h00, v} : {v, 6'h00};
   endfunction

   function automatic int div_of(input logic [1:0] c);
      return c == 2'h0 ? 2 : c == 2'h1 ? 8 : 32;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (failures == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // register port cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   task automatic settle();
      repeat (2) @(posedge clock_i);
      #1;
   endtask

   // one conversion; mode 1 aborts by write, mode 2 runs under sleep
   task automatic conv(input logic [1:0] k, input logic [2:0] c,
                       input logic f, input int mode);
      logic [7:0] v, h, l;
      int         t0, n, dv;
      logic       ab;
      ab = (mode == 1) || (mode == 2 && k != CLK_RC);
      dv = div_of(k);
      wr(OFS_PORT_CONFIG_FIELD, {f, 7'h00});
      wr(OFS_CTRL_A, {k, c, 3'h1});
      wr(OFS_STAT, 8'h00);
      repeat (30) @(posedge clock_i); // acquisition time
      wr(OFS_CTRL_A, {k, c, 3'h5});
      t0 = cyc;
      if (mode == 2) sleep_i <= 1'b1;
      if (ab) begin
         repeat (40) @(posedge clock_i);
         if (mode == 1) wr(OFS_CTRL_A, {k, c, 3'h1});
         settle();
         if (mode == 2) chk(16'(conv_power_o), 16'h0000);
         rd(OFS_CTRL_A, v);
         chk(16'(v), 16'({k, c, 3'h1}));
      end else begin
         rd(OFS_CTRL_A, v);
         chk(16'(v[CA_GO]), 16'h0001);
         n = 0;
         while (v[CA_GO] === 1'b1 && n < 4000) begin
            rd(OFS_CTRL_A, v);
            n++;
         end
         chk(16'(n == 4000), 16'h0000);
         if (n == 4000) end_of_test();
         chk(16'({sample_o, irq_flag}), 16'h0001);
         if (k != CLK_RC)
            chk(16'(cyc - t0 >= 10 * dv && cyc - t0 <= 12 * dv + 24), 16'h0001);
         last_res = exp_res(lvl[c], f);
      end
      rd(OFS_RES_H, h);
      rd(OFS_RES_L, l);
      chk({h, l}, last_res);
      rd(OFS_STAT, v);
      chk(16'(v), ab ? 16'h0000 : 16'h0001);
      if (!ab && k != CLK_RC) begin
         repeat (3 * dv + 8) @(posedge clock_i);
         #1 chk(16'(sample_o), 16'h0001);
      end
      sleep_i <= 1'b0;
      repeat (80) @(posedge clock_i);
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clock_i);
      chk(16'h0001, 16'h0000);
      end_of_test();
   end

   // main sequence
   initial begin
      {resetn_i, wr_i, rd_i, sleep_i} = 4'h0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      lvl = '0;
      last_res = 16'h0000;
      rnd = 32'h3F7E;
      repeat (16) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(OFS_CTRL_A, d);
      chk(16'(d), 16'h0000);
      rd(OFS_PORT_CONFIG_FIELD, d);
      chk(16'(d), 16'h0000);
      rd(8'h55, d);
      chk(16'(d), 16'h0000);
      @(posedge clock_i);
      #1 chk(16'(rdata_o), 16'h0000); // read data stands one cycle only
      chk(16'({conv_power_o, analog_pin_o}), 16'h001F);
      wr(OFS_CTRL_A, 8'hFA);
      rd(OFS_CTRL_A, d);
      chk(16'(d), 16'h00F8);
      wr(OFS_PORT_CONFIG_FIELD, 8'hFF);
      rd(OFS_PORT_CONFIG_FIELD, d);
      chk(16'(d), 16'h008F);
      wr(OFS_CTRL_A, 8'h04);
      rd(OFS_CTRL_A, d);
      chk(16'({d, conv_power_o}), 16'h0000);
      wr(OFS_CTRL_A, 8'h01);
      settle();
      chk(16'(conv_power_o), 16'h0001);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_CTRL_A, {2'h2, 3'(c), 3'h1});
         settle();
         chk(16'(chan_sel_o), c < 5 ? 16'(1 << c) : 16'h0000);
      end
      for (int c = 0; c < 16; c++) begin
         wr(OFS_PORT_CONFIG_FIELD, 8'(c));
         settle();
         chk(16'({vref_pos_pin_o, vref_neg_pin_o, analog_pin_o}),
             16'(exp_cfg(4'(c))));
      end
      for (int i = 0; i < 10; i++) begin
         rnd = lfsr(rnd);
         ch = 3'(rnd[7:0] % 5);
         ck = 2'(i);
         lvl[ch] = ck == 2'h0 ? 10'h3FF : i == 1 ? 10'h000 :
                   i == 2 ? 10'h200 : rnd[25:16];
         conv(ck, ch, rnd[8], 0);
      end
      rnd = lfsr(rnd);
      lvl = {5{rnd[9:0]}};
      conv(2'h2, 3'h1, 1'b0, 1);
      conv(2'h1, 3'h2, 1'b1, 2);
      conv(2'h3, 3'h3, 1'b0, 2);
      // reset in mid conversion with digital pins configured
      wr(OFS_PORT_CONFIG_FIELD, 8'h06);
      wr(OFS_CTRL_A, 8'h81);
      wr(OFS_CTRL_A, 8'h85);
      repeat (50) @(posedge clock_i);
      resetn_i <= 1'b0;
      settle();
      chk(16'({conv_power_o, sample_o, chan_sel_o, analog_pin_o}),
          16'h001F);
      resetn_i <= 1'b1;
      rd(OFS_RES_H, d);
      chk(16'(d), 16'(last_res[15:8]));
      rd(OFS_RES_L, d);
      chk(16'(d), 16'(last_res[7:0]));
      rd(OFS_CTRL_A, d);
      chk(16'(d), 16'h0000);
      end_of_test();
   end
endmodule
